/* File: hdl/cab_addr_branch.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1 - extended: opcode, address high, address low
// RULE2 - indexed no offset: zero high, index low
// RULE3 - eight-bit offset plus index, up to 510
// RULE4 - sixteen-bit offset high first plus index
// RULE5 - relative only for branches, else next
// RULE6 - signed displacement from following instruction address
// RULE7 - lower 0x25 branches on carry, 3 cycles
// RULE8 - lower-or-same 0x23 on carry or zero
// RULE9 - mask-clear 0x2C branches when mask zero
// RULE10 - mask-set 0x2D and negative 0x2B branches
// RULE11 - bit test updates only negative, zero
module cab_addr_branch (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// instruction stream, one whole instruction per start
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  operand_hi,
	input  wire logic [7:0]  operand_lo,
	input  wire logic [15:0] pc,
	// cpu state
	input  wire logic [7:0]  index_value,
	input  wire logic [7:0]  accumulator,
	input  wire logic [7:0]  memory_data,
	input  wire logic [7:0]  ccr_in,
	// results
	output logic             busy,
	output logic             done,
	output logic [15:0]      eff_addr,
	output logic             addr_valid,
	output logic [15:0]      next_pc,
	output logic             branch_taken,
	output logic [7:0]       ccr_out
);
	typedef enum logic [1:0] {CAB_IDLE, CAB_WAIT, CAB_DONE} cab_state_t;

	cab_state_t         state_reg, state_next;
	logic [1:0]         cnt_reg, cnt_next;
	logic [15:0]        ea_reg, ea_next;
	logic               av_reg, av_next;
	logic [15:0]        npc_reg, npc_next;
	logic               tk_reg, tk_next;
	logic [7:0]         ccr_reg, ccr_next;
	cab_pkg::cab_mode_t mode;
	logic               is_branch;
	logic               cond;
	logic [15:0]        base;
	logic [15:0]        offs;
	logic [15:0]        sum;
	logic [15:0]        seq_pc;
	logic [15:0]        disp;
	logic [15:0]        target;
	logic [7:0]         anded;

	always_comb begin
		mode      = cab_pkg::CAB_MODE_NONE;
		is_branch = 1'b0;
		cond      = 1'b0;
		unique case (opcode)
			cab_pkg::OP_BIT_IMMEDIATE: mode = cab_pkg::CAB_MODE_IMMEDIATE;
			cab_pkg::OP_BIT_DIRECT:    mode = cab_pkg::CAB_MODE_DIRECT;
			cab_pkg::OP_BIT_EXTENDED:  mode = cab_pkg::CAB_MODE_EXTENDED;
			cab_pkg::OP_BIT_IX16:      mode = cab_pkg::CAB_MODE_IX16;
			cab_pkg::OP_BIT_IX8:       mode = cab_pkg::CAB_MODE_IX8;
			cab_pkg::OP_BIT_IX0:       mode = cab_pkg::CAB_MODE_IX0;
			cab_pkg::OP_BRANCH_IF_LOWER: begin
				is_branch = 1'b1;
				cond      = ccr_in[cab_pkg::CCR_C]; // [RULE7]
			end
			cab_pkg::OP_BRANCH_IF_LOWER_OR_SAME: begin
				is_branch = 1'b1;
				cond      = ccr_in[cab_pkg::CCR_C] | ccr_in[cab_pkg::CCR_Z]; // [RULE8]
			end
			cab_pkg::OP_BRANCH_IF_MASK_CLEAR: begin
				is_branch = 1'b1;
				cond      = ~ccr_in[cab_pkg::CCR_I]; // [RULE9]
			end
			cab_pkg::OP_BRANCH_IF_MASK_SET: begin
				is_branch = 1'b1;
				cond      = ccr_in[cab_pkg::CCR_I]; // [RULE10]
			end
			cab_pkg::OP_BRANCH_IF_NEGATIVE: begin
				is_branch = 1'b1;
				cond      = ccr_in[cab_pkg::CCR_N]; // [RULE10]
			end
			default: mode = cab_pkg::CAB_MODE_NONE;
		endcase
		if (is_branch) begin
			mode = cab_pkg::CAB_MODE_RELATIVE; // [RULE5]
		end
	end

	// one adder serves the eight- and sixteen-bit offset index modes and branch targets; modes never overlap
	always_comb begin
		base = {cab_pkg::ZERO_PAGE_HIGH, index_value};
		offs = 16'h0000;
		unique case (mode)
			cab_pkg::CAB_MODE_IX8:      offs = {cab_pkg::ZERO_PAGE_HIGH, operand_hi}; // [RULE3]
			cab_pkg::CAB_MODE_IX16:     offs = {operand_hi, operand_lo}; // [RULE4]
			cab_pkg::CAB_MODE_RELATIVE: begin
				base = seq_pc;
				offs = disp;
			end
			default:                    offs = 16'h0000;
		endcase
	end

	assign seq_pc = pc + cab_pkg::LEN_TWO_BYTES; // [RULE6]
	assign disp   = {{8{operand_hi[7]}}, operand_hi}; // [RULE6]
	assign target = sum;
	assign anded  = accumulator & memory_data;

	cab_adder u_adder (
		.base   (base),
		.offset (offs),
		.sum    (sum)
	);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		ea_next    = ea_reg;
		av_next    = av_reg;
		npc_next   = npc_reg;
		tk_next    = tk_reg;
		ccr_next   = ccr_reg;
		unique case (state_reg)
			CAB_IDLE: begin
				if (start) begin
					ccr_next = ccr_in;
					tk_next  = 1'b0;
					av_next  = 1'b1;
					unique case (mode)
						cab_pkg::CAB_MODE_EXTENDED: begin
							ea_next  = {operand_hi, operand_lo}; // [RULE1]
							npc_next = pc + cab_pkg::LEN_THREE_BYTES; // [RULE1]
						end
						cab_pkg::CAB_MODE_IX0: begin
							ea_next  = {cab_pkg::ZERO_PAGE_HIGH, index_value}; // [RULE2]
							npc_next = pc + cab_pkg::LEN_ONE_BYTE; // [RULE2]
						end
						cab_pkg::CAB_MODE_IX8: begin
							ea_next  = sum; // [RULE3]
							npc_next = pc + cab_pkg::LEN_TWO_BYTES; // [RULE3]
						end
						cab_pkg::CAB_MODE_IX16: begin
							ea_next  = sum; // [RULE4]
							npc_next = pc + cab_pkg::LEN_THREE_BYTES; // [RULE4]
						end
						cab_pkg::CAB_MODE_DIRECT: begin
							ea_next  = {cab_pkg::ZERO_PAGE_HIGH, operand_hi};
							npc_next = pc + cab_pkg::LEN_TWO_BYTES;
						end
						cab_pkg::CAB_MODE_IMMEDIATE: begin
							ea_next  = pc + cab_pkg::LEN_ONE_BYTE;
							npc_next = pc + cab_pkg::LEN_TWO_BYTES;
						end
						cab_pkg::CAB_MODE_RELATIVE: begin
							av_next  = 1'b0;
							tk_next  = cond;
							npc_next = cond ? target : seq_pc; // [RULE5]
						end
						cab_pkg::CAB_MODE_NONE: begin
							av_next  = 1'b0;
							npc_next = pc + cab_pkg::LEN_ONE_BYTE;
						end
					endcase
					if (mode == cab_pkg::CAB_MODE_RELATIVE) begin
						cnt_next   = cab_pkg::BRANCH_CYCLES - 2'h1; // [RULE7]
						state_next = CAB_WAIT;
					end else begin
						state_next = CAB_DONE;
					end
					if (opcode[3:0] == cab_pkg::OP_BIT_IMMEDIATE[3:0] && av_next) begin
						ccr_next[cab_pkg::CCR_N] = anded[7]; // [RULE11]
						ccr_next[cab_pkg::CCR_Z] = (anded == 8'h00); // [RULE11]
					end
				end
			end
			CAB_WAIT: begin
				cnt_next = cnt_reg - 2'h1;
				if (cnt_reg == 2'h1) begin
					state_next = CAB_DONE;
				end
			end
			CAB_DONE: state_next = CAB_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= CAB_IDLE;
			cnt_reg   <= 2'h0;
			ea_reg    <= 16'h0000;
			av_reg    <= 1'b0;
			npc_reg   <= 16'h0000;
			tk_reg    <= 1'b0;
			ccr_reg   <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			ea_reg    <= ea_next;
			av_reg    <= av_next;
			npc_reg   <= npc_next;
			tk_reg    <= tk_next;
			ccr_reg   <= ccr_next;
		end
	end

	assign busy         = (state_reg != CAB_IDLE);
	assign done         = (state_reg == CAB_DONE);
	assign eff_addr     = ea_reg;
	assign addr_valid   = av_reg;
	assign next_pc      = npc_reg;
	assign branch_taken = tk_reg;
	assign ccr_out      = ccr_reg;

	// branches leave flags alone and finish 3 cycles after start
	chk_branch_flags: assert property (@(posedge clock) disable iff (!arst_n) // [RULE7]
		(start && !busy && is_branch) |=> (ccr_out == $past(ccr_in)))
		else $error("branch changed flags");
	chk_branch_time: assert property (@(posedge clock) disable iff (!arst_n) // [RULE7]
		(start && !busy && is_branch) |-> ##3 done)
		else $error("branch not done in 3 cycles");
	chk_ix0_addr: assert property (@(posedge clock) disable iff (!arst_n) // [RULE2]
		(start && !busy && opcode == cab_pkg::OP_BIT_IX0) |=> eff_addr[15:8] == 8'h00)
		else $error("no-offset high byte not zero");
	chk_ix8_range: assert property (@(posedge clock) disable iff (!arst_n) // [RULE3]
		(start && !busy && opcode == cab_pkg::OP_BIT_IX8) |=> eff_addr <= cab_pkg::IX8_LAST_ADDR)
		else $error("eight-bit indexed out of range");
	chk_ext_addr: assert property (@(posedge clock) disable iff (!arst_n) // [RULE1]
		(start && !busy && opcode == cab_pkg::OP_BIT_EXTENDED)
		|=> eff_addr == {$past(operand_hi), $past(operand_lo)})
		else $error("extended address wrong");
	chk_ix16_addr: assert property (@(posedge clock) disable iff (!arst_n) // [RULE4]
		(start && !busy && opcode == cab_pkg::OP_BIT_IX16)
		|=> eff_addr == {$past(operand_hi), $past(operand_lo)} + {8'h00, $past(index_value)})
		else $error("sixteen-bit indexed wrong");
	chk_not_taken: assert property (@(posedge clock) disable iff (!arst_n) // [RULE5]
		(start && !busy && is_branch && !cond)
		|=> next_pc == $past(pc) + cab_pkg::LEN_TWO_BYTES && !branch_taken)
		else $error("untaken branch target wrong");
	chk_taken_tgt: assert property (@(posedge clock) disable iff (!arst_n) // [RULE6]
		(start && !busy && is_branch && cond)
		|=> next_pc == $past(pc) + cab_pkg::LEN_TWO_BYTES
			+ {{8{$past(operand_hi[7])}}, $past(operand_hi)})
		else $error("taken branch target wrong");
	chk_bit_flags: assert property (@(posedge clock) disable iff (!arst_n) // [RULE11]
		(start && !busy && opcode == cab_pkg::OP_BIT_IX8)
		|=> ccr_out[cab_pkg::CCR_C] == $past(ccr_in[cab_pkg::CCR_C])
		&& ccr_out[cab_pkg::CCR_Z] == ($past(accumulator & memory_data) == 8'h00))
		else $error("bit test flags wrong");
	chk_mask_set: assert property (@(posedge clock) disable iff (!arst_n) // [RULE10]
		(start && !busy && opcode == cab_pkg::OP_BRANCH_IF_MASK_SET)
		|=> branch_taken == $past(ccr_in[cab_pkg::CCR_I]))
		else $error("mask-set decision wrong");
	chk_lower_same: assert property (@(posedge clock) disable iff (!arst_n) // [RULE8]
		(start && !busy && opcode == cab_pkg::OP_BRANCH_IF_LOWER_OR_SAME)
		|=> branch_taken == ($past(ccr_in[cab_pkg::CCR_C]) | $past(ccr_in[cab_pkg::CCR_Z])))
		else $error("lower-or-same decision wrong");
endmodule : cab_addr_branch

/* File: hdl/cab_pkg.sv */
package cab_pkg;
	localparam logic [7:0] OP_BRANCH_IF_LOWER         = 8'h25;
	localparam logic [7:0] OP_BRANCH_IF_LOWER_OR_SAME = 8'h23;
	localparam logic [7:0] OP_BRANCH_IF_MASK_CLEAR    = 8'h2C;
	localparam logic [7:0] OP_BRANCH_IF_MASK_SET      = 8'h2D;
	localparam logic [7:0] OP_BRANCH_IF_NEGATIVE      = 8'h2B;
	localparam logic [7:0] OP_BIT_IMMEDIATE           = 8'hA5;
	localparam logic [7:0] OP_BIT_DIRECT              = 8'hB5;
	localparam logic [7:0] OP_BIT_EXTENDED            = 8'hC5;
	localparam logic [7:0] OP_BIT_IX16                = 8'hD5;
	localparam logic [7:0] OP_BIT_IX8                 = 8'hE5;
	localparam logic [7:0] OP_BIT_IX0                 = 8'hF5;
	localparam logic [7:0] ZERO_PAGE_HIGH             = 8'h00;
	localparam logic [1:0] BRANCH_CYCLES              = 2'h3;
	localparam logic [15:0] LEN_ONE_BYTE              = 16'h0001;
	localparam logic [15:0] LEN_TWO_BYTES             = 16'h0002;
	localparam logic [15:0] LEN_THREE_BYTES           = 16'h0003;
	localparam logic [15:0] IX8_LAST_ADDR             = 16'h01FE;
	// ccr bit positions
	localparam int CCR_C = 0;
	localparam int CCR_Z = 1;
	localparam int CCR_N = 2;
	localparam int CCR_I = 3;
	typedef enum logic [2:0] {
		CAB_MODE_IMMEDIATE,
		CAB_MODE_DIRECT,
		CAB_MODE_EXTENDED,
		CAB_MODE_IX16,
		CAB_MODE_IX8,
		CAB_MODE_IX0,
		CAB_MODE_RELATIVE,
		CAB_MODE_NONE
	} cab_mode_t;
endpackage : cab_pkg

/* File: hdl/cab_adder.sv */
`timescale 1ns/1ps
// 16-bit add used for both operand address and branch target
module cab_adder (
	input  wire logic [15:0] base,
	input  wire logic [15:0] offset,
	output logic      [15:0] sum
);
	assign sum = base + offset;
endmodule : cab_adder

/* File: bench/cab_addr_branch_bench.sv */
`timescale 1ns/1ps
module cab_addr_branch_bench;
	logic        clock       = 1'b0;
	logic        arst_n      = 1'b0;
	logic        start       = 1'b0;
	logic [7:0]  opcode      = 8'h00;
	logic [7:0]  operand_hi  = 8'h00;
	logic [7:0]  operand_lo  = 8'h00;
	logic [15:0] pc          = 16'h0000;
	logic [7:0]  index_value = 8'h00;
	logic [7:0]  accumulator = 8'h00;
	logic [7:0]  memory_data = 8'h00;
	logic [7:0]  ccr_in      = 8'h00;
	logic        busy;
	logic        done;
	logic [15:0] eff_addr;
	logic        addr_valid;
	logic [15:0] next_pc;
	logic        branch_taken;
	logic [7:0]  ccr_out;
	int          n_errors     = 0;
	int          total_checks = 0;

	always #2.5 clock = ~clock;

	cab_addr_branch i_dut (.clock(clock), .arst_n(arst_n), .start(start), .opcode(opcode),
		.operand_hi(operand_hi), .operand_lo(operand_lo), .pc(pc), .index_value(index_value),
		.accumulator(accumulator), .memory_data(memory_data), .ccr_in(ccr_in), .busy(busy),
		.done(done), .eff_addr(eff_addr), .addr_valid(addr_valid), .next_pc(next_pc),
		.branch_taken(branch_taken), .ccr_out(ccr_out));

	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk16

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		chk16(nm, {8'h00, e}, {8'h00, g});
	endtask : chk8

	task automatic chk1(input string nm, input logic e, input logic g);
		chk16(nm, {15'h0000, e}, {15'h0000, g});
	endtask : chk1

	// one whole instruction; cyc counts edges from the taking edge up to the one after which done is seen
	task automatic issue(input logic [7:0] op, hi, lo, input logic [15:0] p,
		input logic [7:0] idx, acc, mem, ccr, output int cyc);
		@(posedge clock);
		opcode <= op;
		operand_hi <= hi;
		operand_lo <= lo;
		pc <= p;
		index_value <= idx;
		accumulator <= acc;
		memory_data <= mem;
		ccr_in <= ccr;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		cyc = 1;
		// done settles just after an edge and is sampled 1 ns after that same edge
		#1;
		while (done !== 1'b1 && cyc < 8) begin
			@(posedge clock);
			#1;
			cyc++;
		end
	endtask : issue

	task automatic test_bit_modes(input logic [7:0] hi, lo, idx, acc, mem, ccr);
		logic [7:0]  ops [6];
		logic [15:0] addr [6];
		logic [15:0] npc [6];
		logic [7:0]  r;
		logic [7:0]  e;
		int          cyc;
		ops = '{8'hA5, 8'hB5, 8'hC5, 8'hD5, 8'hE5, 8'hF5};
		addr = '{16'h1000, {8'h00, hi}, {hi, lo}, {hi, lo} + {8'h00, idx},
			{8'h00, hi} + {8'h00, idx}, {8'h00, idx}};
		// opcode at 16'h0FFF: two, two, three, three, two and one bytes long
		npc = '{16'h1001, 16'h1001, 16'h1002, 16'h1002, 16'h1001, 16'h1000};
		r = acc & mem;
		e = ccr;
		e[cab_pkg::CCR_N] = r[7];
		e[cab_pkg::CCR_Z] = (r == 8'h00);
		for (int i = 0; i < 6; i++) begin
			issue(ops[i], hi, lo, 16'h0FFF, idx, acc, mem, ccr, cyc);
			chk16("bit cycles", 16'h0001, 16'(cyc));
			chk1("bit busy at done", 1'b1, busy);
			chk16("bit next_pc", npc[i], next_pc);
			chk1("bit branch_taken", 1'b0, branch_taken);
			chk16("eff_addr", addr[i], eff_addr);
			chk1("addr_valid", 1'b1, addr_valid);
			chk8("bit flags", e, ccr_out);
		end
	endtask : test_bit_modes

	task automatic test_branches;
		// opcode, flags in, taken; other flag bits set when the tested bit is clear and clear when it is set, to catch a wrong bit
		logic [16:0] cs [11] = '{{8'h25, 8'h01, 1'b1}, {8'h25, 8'hFE, 1'b0},
			{8'h23, 8'h02, 1'b1}, {8'h23, 8'h01, 1'b1}, {8'h23, 8'hFC, 1'b0},
			{8'h2C, 8'hF7, 1'b1}, {8'h2C, 8'h08, 1'b0}, {8'h2D, 8'h08, 1'b1},
			{8'h2D, 8'hF7, 1'b0}, {8'h2B, 8'h04, 1'b1}, {8'h2B, 8'hFB, 1'b0}};
		logic [7:0]  d;
		logic [15:0] exp;
		int          cyc;
		for (int i = 0; i < 11; i++) begin
			d = i[0] ? 8'h7F : 8'h80;
			issue(cs[i][16:9], d, 8'h3C, 16'h1000, 8'h55, 8'hFF, 8'hFF, cs[i][8:1], cyc);
			exp = cs[i][0] ? 16'h1002 + {{8{d[7]}}, d} : 16'h1002;
			chk16("branch cycles", 16'h0003, 16'(cyc));
			chk16("next_pc", exp, next_pc);
			chk1("branch_taken", cs[i][0], branch_taken);
			chk8("branch flags", cs[i][8:1], ccr_out);
			chk1("branch addr_valid", 1'b0, addr_valid);
		end
	endtask : test_branches

	// reset while idle after the last branch, then an opcode outside the block's set with a 5 low nibble
	task automatic test_reset_unknown;
		int cyc;
		@(posedge clock);
		arst_n <= 1'b0;
		@(posedge clock);
		#1;
		chk16("reset next_pc", 16'h0000, next_pc);
		chk8("reset ccr_out", 8'h00, ccr_out);
		chk1("reset busy", 1'b0, busy);
		chk1("reset addr_valid", 1'b0, addr_valid);
		@(posedge clock);
		arst_n <= 1'b1;
		issue(8'h05, 8'h00, 8'h00, 16'h2000, 8'h00, 8'hFF, 8'hFF, 8'h09, cyc);
		chk16("unknown cycles", 16'h0001, 16'(cyc));
		chk16("unknown next_pc", 16'h2001, next_pc);
		chk1("unknown addr_valid", 1'b0, addr_valid);
		chk1("unknown branch_taken", 1'b0, branch_taken);
		chk8("unknown flags", 8'h09, ccr_out);
	endtask : test_reset_unknown

	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// whole run is well under 300 cycles
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		report_and_stop();
	end

	initial begin
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		test_bit_modes(8'h12, 8'hF0, 8'hFF, 8'h80, 8'hC1, 8'h0B);
		test_bit_modes(8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hF0, 8'h04);
		test_branches();
		test_reset_unknown();
		report_and_stop();
	end
endmodule : cab_addr_branch_bench
